/* atrw_compare.sv */
// Signed limit comparison that yields the three flag bits.
module atrw_compare
(
  input  wire logic [12:0] temp,
  input  wire logic [12:0] critical_limit,
  input  wire logic [12:0] window_high_limit,
  input  wire logic [12:0] window_low_limit,
  output logic      [2:0]  flags
);

  // Signed compares; alert configuration never enters here.
  always_comb
  begin
    flags[2] = $signed(temp) >= $signed(critical_limit);
    flags[1] = $signed(temp) >  $signed(window_high_limit);
    flags[0] = $signed(temp) <  $signed(window_low_limit);
  end

endmodule // atrw_compare

/* atrw_host_model.sv */
// Host model that reads a register upper byte first, then lower.
module atrw_host_model
(
  input  wire logic               clk,
  input  wire logic [7:0]         rbyte,
  input  wire logic               valid,
  output atrw_pkg::atrw_read_type req
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each byte is asked for only after the previous answer has landed; the valid pulse
  // is recorded beside each byte so the bench can see both answers really arrived.
  task automatic read(input logic [7:0] ptr, output logic [15:0] w, output logic [1:0] vld);
    @(negedge clk) req = '{1'b1, 1'b0, ptr};
    @(negedge clk) w[15:8] = rbyte;
    vld[1] = valid;
    req = '{1'b0, 1'b1, ptr};
    @(negedge clk) w[7:0] = rbyte;
    vld[0] = valid;
    req.next = 1'b0;
  endtask
  // Host conversion in sixteenths of a degree; below zero it gives the distance under zero.
  function automatic int to_sixteenths(input logic [15:0] w);
    logic [7:0] upper;
    logic [7:0] lower;
    upper = w[15:8] & 8'h1F;
    lower = w[7:0];
    if (upper[4])
    begin
      upper = upper & 8'h0F;
      to_sixteenths = 32'h00001000 - int'({upper, lower});
    end
    else
    begin
      to_sixteenths = int'({upper, lower});
    end
  endfunction
  initial req = '0;
endmodule // atrw_host_model

/* atrw_pkg.sv */
// Package with constants and carrier types for the ambient temperature result word block.
package atrw_pkg;

  // Register pointer values.
  localparam logic [7:0]  PTR_AMBIENT      = 8'h05;
  localparam logic [7:0]  PTR_MAKER_ID     = 8'h06;

  // Maker identification value; the value is arbitrary.
  localparam logic [15:0] MAKER_ID_VALUE   = 16'h0A5C;

  // Field positions of the result word.
  localparam int          BIT_CRIT         = 15;
  localparam int          BIT_HIGH         = 14;
  localparam int          BIT_LOW          = 13;
  localparam int          BIT_SIGN         = 12;
  localparam int          TEMP_MSB         = 11;
  localparam int          TEMP_W           = 13;

  // Resolution codes: 0.5, 0.25, 0.125 and 0.0625 degrees per bit.
  localparam logic [1:0]  RES_HALF         = 2'h0;
  localparam logic [1:0]  RES_QUARTER      = 2'h1;
  localparam logic [1:0]  RES_EIGHTH       = 2'h2;
  localparam logic [1:0]  RES_SIXTEENTH    = 2'h3;
  localparam logic [1:0]  RES_RESET        = RES_QUARTER;

  // Low-bit masks that clear unused fraction bits for each resolution.
  localparam logic [15:0] MASK_HALF        = 16'hFFF8;
  localparam logic [15:0] MASK_QUARTER     = 16'hFFFC;
  localparam logic [15:0] MASK_EIGHTH      = 16'hFFFE;
  localparam logic [15:0] MASK_SIXTEENTH   = 16'hFFFF;

  localparam logic [15:0] WORD_RESET       = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;

  // Conversion result as it leaves the converter.
  typedef struct packed {
    logic                done;
    logic [TEMP_W-1:0]   temp;
  } atrw_sample_type;

  // Limit values in the same 13-bit two's complement form.
  typedef struct packed {
    logic [TEMP_W-1:0]   critical;
    logic [TEMP_W-1:0]   high;
    logic [TEMP_W-1:0]   low;
  } atrw_limits_type;

  // One byte request from the serial engine.
  typedef struct packed {
    logic                start;
    logic                next;
    logic [7:0]          pointer;
  } atrw_read_type;

endpackage

/* atrw_result_word.sv */
// Ambient temperature result word with double buffering and byte readout.
//
// Contract
// - Bit 15 is 1 when the temperature is at or above the critical limit, else 0.
// - Bit 14 is 1 when the temperature is strictly above the window high limit, else 0.
// - Bit 13 is 1 when the temperature is strictly below the window low limit, else 0.
// - The three flags follow the compares and alert configuration never alters them.
// - Bit 12 is the sign, 1 below zero degrees and 0 otherwise.
// - Bits 11 to 0 hold two's complement temperature with bit 0 worth 1/16 degree.
// - The upper byte holds flags, sign and weights of 16 degrees up; the lower byte the rest.
// - Unused low fraction bits among bits 2 to 0 read zero according to resolution.
// - After reset the resolution is a quarter degree so bits 1 and 0 read zero.
// - The upper byte is returned first, then the lower; the host acks, nacks and stops.
// - A read-only maker identification word is provided.
// - The word is double-buffered and reloaded in parallel at each conversion end.
// - The word is a 16-bit read-only register at pointer 0000 0101 binary.
//
// Conversion ends arrive as one-cycle done pulses from the converter; the limits are levels.
// The serial engine asks for bytes with start and next pulses, answered one cycle later.
// Limitation: a new resolution shapes only the next conversion, never the stored word.
// Trade-off: the limit compares run on the incoming sample, so the flags and the
// temperature they describe are always loaded together at one edge.
module atrw_result_word
(
  input  wire logic                     REF_CLK,
  input  wire logic                     RESET,
  input  wire atrw_pkg::atrw_sample_type SAMPLE,
  input  wire atrw_pkg::atrw_limits_type LIMITS,
  input  wire logic [1:0]               RESOLUTION,
  input  wire logic                     RESOLUTION_WRITE,
  input  wire atrw_pkg::atrw_read_type   READ_REQ,
  output logic      [7:0]               READ_BYTE,
  output logic                          READ_VALID,
  output logic      [15:0]              AMBIENT_TEMP_WORD,
  output logic      [1:0]               RESOLUTION_NOW
);

  // Read sequencer: after a start the lower byte of the snapshot is still owed.
  typedef enum logic {read_idle, read_low_owed} atrw_read_state_type;

  logic [2:0]          flags;
  logic [15:0]         res_mask;
  logic [15:0]         field_word;
  logic [15:0]         loaded_word;
  logic [15:0]         word;
  logic [15:0]         next_word;
  logic [1:0]          resolution;
  logic [1:0]          next_resolution;
  logic [15:0]         pointed_word;
  logic [15:0]         shadow;
  logic [15:0]         next_shadow;
  atrw_read_state_type read_state;
  atrw_read_state_type next_read_state;
  logic [7:0]          read_byte;
  logic [7:0]          next_read_byte;
  logic                read_valid;
  logic                next_read_valid;

  // Flags come from the new sample so they match the temperature they sit beside.
  atrw_compare i_atrw_compare
  (
    .temp              (SAMPLE.temp),
    .critical_limit    (LIMITS.critical),
    .window_high_limit (LIMITS.high),
    .window_low_limit  (LIMITS.low),
    .flags             (flags)
  );

  // Mask of fraction bits kept at the current resolution.
  always_comb
  begin
    case (resolution)
      atrw_pkg::RES_HALF:      res_mask = atrw_pkg::MASK_HALF;
      atrw_pkg::RES_QUARTER:   res_mask = atrw_pkg::MASK_QUARTER;
      atrw_pkg::RES_EIGHTH:    res_mask = atrw_pkg::MASK_EIGHTH;
      atrw_pkg::RES_SIXTEENTH: res_mask = atrw_pkg::MASK_SIXTEENTH;
      default:                 res_mask = atrw_pkg::MASK_QUARTER;
    endcase
  end

  // Field assembly: flags on top, then the sign, then the two's complement temperature.
  // No alert output setting reaches this point, so the flags can never be masked.
  always_comb
  begin
    field_word                       = atrw_pkg::WORD_RESET;
    field_word[atrw_pkg::BIT_CRIT]   = flags[2];
    field_word[atrw_pkg::BIT_HIGH]   = flags[1];
    field_word[atrw_pkg::BIT_LOW]    = flags[0];
    field_word[atrw_pkg::BIT_SIGN]   = SAMPLE.temp[atrw_pkg::BIT_SIGN];
    field_word[atrw_pkg::TEMP_MSB:0] = SAMPLE.temp[atrw_pkg::TEMP_MSB:0];
  end

  // Unused fraction bits are cleared before the word is stored, never on the way out.
  always_comb
  begin
    loaded_word = field_word & res_mask;
  end

  // Result word reloads whole at conversion end only, so reads never see a torn value.
  // Between done pulses the word simply holds, which is the double buffer the host relies on.
  always_comb
  begin
    next_word = word;
    if (SAMPLE.done)
    begin
      next_word = loaded_word;
    end
  end

  // Result word register; it reads zero until the first conversion ends.
  // A reset mid-run drops the last result as well, so stale data never survives it.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      word <= atrw_pkg::WORD_RESET;
    end
    else
    begin
      word <= next_word;
    end
  end

  // A new resolution only shapes later conversions; the stored word is not re-masked.
  always_comb
  begin
    next_resolution = resolution;
    if (RESOLUTION_WRITE)
    begin
      next_resolution = RESOLUTION;
    end
  end

  // Resolution register, a quarter degree out of reset.
  // The code is held here because both the mask and the status output read it.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      resolution <= atrw_pkg::RES_RESET;
    end
    else
    begin
      resolution <= next_resolution;
    end
  end

  // Register select by pointer; an unmapped pointer reads as zero rather than stale data.
  // Only the word and the maker code are reachable here; other registers live elsewhere.
  always_comb
  begin
    case (READ_REQ.pointer)
      atrw_pkg::PTR_AMBIENT:  pointed_word = word;
      atrw_pkg::PTR_MAKER_ID: pointed_word = atrw_pkg::MAKER_ID_VALUE;
      default:                pointed_word = atrw_pkg::WORD_RESET;
    endcase
  end

  // Byte readout: a start latches a snapshot and sends the upper byte, next sends the lower.
  // The snapshot keeps both bytes from one conversion even if a reload lands between them.
  // A next with no lower byte owed answers zero rather than repeating an old byte.
  always_comb
  begin
    next_shadow     = shadow;
    next_read_state = read_state;
    next_read_byte  = read_byte;
    next_read_valid = 1'b0;
    if (READ_REQ.start)
    begin
      next_shadow     = pointed_word;
      next_read_state = read_low_owed;
      next_read_valid = 1'b1;
      next_read_byte  = pointed_word[15:8];
    end
    else if (READ_REQ.next)
    begin
      next_read_state = read_idle;
      next_read_valid = 1'b1;
      case (read_state)
        read_low_owed: next_read_byte = shadow[7:0];
        read_idle:     next_read_byte = atrw_pkg::BYTE_ZERO;
        default:       next_read_byte = atrw_pkg::BYTE_ZERO;
      endcase
    end
  end

  // Readout registers; the valid pulse lasts one cycle while the byte stands until the next ask.
  // Reset leaves no lower byte owed, so a stray next after reset answers zero.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      shadow     <= atrw_pkg::WORD_RESET;
      read_state <= read_idle;
      read_byte  <= atrw_pkg::BYTE_ZERO;
      read_valid <= 1'b0;
    end
    else
    begin
      shadow     <= next_shadow;
      read_state <= next_read_state;
      read_byte  <= next_read_byte;
      read_valid <= next_read_valid;
    end
  end

  // Outputs straight from flip-flops.
  always_comb
  begin
    READ_BYTE         = read_byte;
    READ_VALID        = read_valid;
    AMBIENT_TEMP_WORD = word;
    RESOLUTION_NOW    = resolution;
  end

endmodule // atrw_result_word

/* atrw_result_word_asserts.sv */
// Checker for the result word block, bound to the ports of its top module.
module atrw_result_word_chk
(
  input wire logic                      REF_CLK,
  input wire logic                      RESET,
  input wire atrw_pkg::atrw_sample_type SAMPLE,
  input wire atrw_pkg::atrw_limits_type LIMITS,
  input wire logic [1:0]                RESOLUTION,
  input wire logic                      RESOLUTION_WRITE,
  input wire atrw_pkg::atrw_read_type   READ_REQ,
  input wire logic [7:0]                READ_BYTE,
  input wire logic                      READ_VALID,
  input wire logic [15:0]               AMBIENT_TEMP_WORD,
  input wire logic [1:0]                RESOLUTION_NOW
);
  timeunit 1ns;
  timeprecision 1ns;
  // Signed views of the sample, so that negative limits compare correctly.
  wire logic signed [12:0] t  = SAMPLE.temp;
  wire logic [15:0]        w  = AMBIENT_TEMP_WORD;
  wire logic [7:0]         wu = w[15:8];
  wire logic               fc = t >= $signed(LIMITS.critical);
  wire logic               fh = t > $signed(LIMITS.high);
  wire logic               fl = t < $signed(LIMITS.low);
  wire logic [12:0]        v  = {t[12:3], t[2:0] & ~(3'h7 >> RESOLUTION_NOW)};
  wire logic               dn = SAMPLE.done;
  wire logic               st = READ_REQ.start;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  crit_flag_a: assert property (dn |=> w[15] == $past(fc)) else $error("crit flag");
  high_flag_a: assert property (dn |=> w[14] == $past(fh)) else $error("high flag");
  low_flag_a: assert property (dn |=> w[13] == $past(fl)) else $error("low flag");
  temp_field_a: assert property (dn |=> w[12:0] == $past(v)) else $error("temp");
  word_hold_a: assert property (!dn |=> $stable(w)) else $error("word moved");
  read_valid_a: assert property (st || READ_REQ.next |=> READ_VALID) else $error("valid");
  upper_byte_a: assert property (st && READ_REQ.pointer == atrw_pkg::PTR_AMBIENT
    |=> READ_BYTE == $past(wu)) else $error("upper byte");
  res_load_a: assert property (RESOLUTION_WRITE |=> RESOLUTION_NOW == $past(RESOLUTION))
    else $error("resolution");
  valid_idle_a: assert property (!(st || READ_REQ.next) |=> !READ_VALID)
    else $error("stray valid");
endmodule // atrw_result_word_chk
bind atrw_result_word atrw_result_word_chk i_atrw_result_word_chk (.REF_CLK, .RESET, .SAMPLE,
  .LIMITS, .RESOLUTION, .RESOLUTION_WRITE, .READ_REQ, .READ_BYTE, .READ_VALID,
  .AMBIENT_TEMP_WORD, .RESOLUTION_NOW);

/* tb_atrw_result_word.sv */
// Self-checking bench for the ambient temperature result word.
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module tb_atrw_result_word;
  timeunit 1ns;
  timeprecision 1ns;
  logic                      clk = 1'b0;
  logic                      reset = 1'b1;
  logic                      res_wr = 1'b0;
  logic [1:0]                res = 2'h0;
  logic [1:0]                res_now;
  logic [7:0]                rbyte;
  logic [15:0]               word;
  logic [15:0]               got;
  logic                      valid;
  logic [1:0]                vld;
  int                        num_errors = 0;
  int                        checks_done = 0;
  atrw_pkg::atrw_read_type   req;
  atrw_pkg::atrw_sample_type smp = '0;
  atrw_pkg::atrw_limits_type lim = '{13'h0500, 13'h0400, 13'h0010};
  logic [12:0]               temps [6] = '{13'h0500, 13'h0400, 13'h0401, 13'h0010, 13'h000F,
                                           13'h1E6D};
  initial forever #25 clk = ~clk;
  atrw_result_word i_atrw_result_word (.REF_CLK(clk), .RESET(reset), .SAMPLE(smp),
    .LIMITS(lim), .RESOLUTION(res), .RESOLUTION_WRITE(res_wr), .READ_REQ(req),
    .READ_BYTE(rbyte), .READ_VALID(valid), .AMBIENT_TEMP_WORD(word), .RESOLUTION_NOW(res_now));
  atrw_host_model i_atrw_host_model (.clk(clk), .rbyte(rbyte), .valid(valid), .req(req));
  // Boundary values sit exactly on each limit, where the flags must differ.
  function automatic logic [15:0] expect_word(input logic [12:0] t, input logic [1:0] r);
    expect_word = {$signed(t) >= $signed(lim.critical), $signed(t) > $signed(lim.high),
                   $signed(t) < $signed(lim.low), t} & ~(16'h7 >> r);
  endfunction
  task automatic convert(input logic [12:0] t);
    @(negedge clk) smp = '{1'b1, t};
    @(negedge clk) smp.done = 1'b0;
  endtask
  // Expected host reading in sixteenths; below zero it is the distance under zero degrees.
  function automatic int expect_deg(input logic [12:0] t, input logic [1:0] r);
    logic [12:0] m;
    m = t & ~(13'h0007 >> r);
    expect_deg = m[12] ? 32'h00002000 - int'(m) : int'(m);
  endfunction
  // The resolution in force is passed in, so the expectation never leans on the design.
  task automatic conv_check(input logic [12:0] t, input logic [1:0] r);
    convert(t);
    i_atrw_host_model.read(atrw_pkg::PTR_AMBIENT, got, vld);
    `CHK("word", expect_word(t, r), got)
    `CHK("valid", 2'h3, vld)
    `CHK("degrees", expect_deg(t, r), i_atrw_host_model.to_sixteenths(got))
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence; a reload between the two bytes must not reach the host.
  initial
  begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    `CHK("res", atrw_pkg::RES_QUARTER, res_now)
    `CHK("word rst", atrw_pkg::WORD_RESET, word)
    foreach (temps[i]) conv_check(temps[i], atrw_pkg::RES_QUARTER);
    for (int r = 0; r < 4; r++)
    begin
      @(negedge clk) {res_wr, res} = {1'b1, 2'(r)};
      @(negedge clk) res_wr = 1'b0;
      `CHK("res now", 2'(r), res_now)
      conv_check(13'h0197, 2'(r));
    end
    fork
      i_atrw_host_model.read(atrw_pkg::PTR_AMBIENT, got, vld);
      begin
        @(negedge clk);
        convert(13'h0456);
      end
    join
    `CHK("snapshot", expect_word(13'h0197, atrw_pkg::RES_SIXTEENTH), got)
    `CHK("reload", expect_word(13'h0456, atrw_pkg::RES_SIXTEENTH), word)
    i_atrw_host_model.read(atrw_pkg::PTR_MAKER_ID, got, vld);
    `CHK("id", atrw_pkg::MAKER_ID_VALUE, got)
    i_atrw_host_model.read(8'h07, got, vld);
    `CHK("unmapped", 16'h0000, got)
    // A reset in mid-run must bring back the power-up word and resolution.
    @(negedge clk) reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    `CHK("word rst2", atrw_pkg::WORD_RESET, word)
    `CHK("res rst2", atrw_pkg::RES_QUARTER, res_now)
    conv_check(13'h1FF1, atrw_pkg::RES_QUARTER);
    give_verdict();
  end
  // Cuts a hang short; the sequence needs only a few microseconds.
  initial
  begin
    #100us;
    num_errors++;
    give_verdict();
  end
endmodule // tb_atrw_result_word
